// ---- common/vbd_pkg.sv ----
// constants shared by the video byte decommutator and its test pattern source
// assumes one 50 MHz core clock and a synchronous active-high reset
package vbd_pkg;
	localparam int BYTE_W = 6;
	localparam int DELAY_BYTES = 4;
	localparam int CODE_W = BYTE_W * DELAY_BYTES;
	localparam int CLK_HZ = 50_000_000;
	localparam int BIT_RATE_BPS = 59_500;
	// longest period that still meets the bit rate, so rounded down
	localparam int BYTE_PERIOD_CYC = CLK_HZ * BYTE_W / BIT_RATE_BPS;
	// sync codes, first received byte in the top bits
	localparam logic [CODE_W-1:0] FRAME_CODE = 24'hFC0FC0;
	localparam logic [CODE_W-1:0] LINE_CODE = 24'hFFF000;
	localparam logic [CODE_W-1:0] IDENT_CODE = 24'h03F03F;
	// scan lines per frame for each camera source
	localparam int LINES_PROBE = 280;
	localparam int LINES_LANDER = 200;
	localparam int SAMPLES_PER_LINE = 280;
	localparam int LINE_W = 9;
	// retrace gate lengths in core clocks
	localparam int HRET_CYC = 16;
	localparam int VRET_CYC = 64;
	localparam int RET_W = 8;
	localparam int IDENT_LEN = 32;
	localparam int IDENT_POS_W = 5;
	// identification bytes are shifted into the display character range
	localparam logic [BYTE_W:0] IDENT_CHAR_BASE = 7'h20;
	localparam logic [1:0] PAT_BARS = 2'h0;
	localparam logic [1:0] PAT_RESOLUTION = 2'h1;
	localparam logic [1:0] PAT_GREY = 2'h2;
	typedef enum logic [1:0] {VBD_ROUTE_NONE, VBD_ROUTE_VIDEO, VBD_ROUTE_IDENT} vbd_route_t;
	typedef enum logic [1:0] {VBD_PG_FRAME, VBD_PG_LINE, VBD_PG_SAMPLES} vbd_pg_state_t;
endpackage

// ---- design/vbd_decommutator.sv ----
// video byte decommutator with control unit and sync driver
// assumes host pins are asynchronous and a 50 MHz core clock
// Contract
// - six-bit bytes at 59.5 kbps, one unit each
// - four-byte delay before acting on bytes
// - recognise frame, line and identification codes
// - steer identification, video and sync to consumers
// - sync driver makes sweep gates and blanking
// - cathode bias off in retrace or power fail
// - convert video only on control unit command
// - format identification bytes for the display
// - advance film after a complete frame
// - manual or computer control selects command source
// - test source makes bars, resolution, grey patterns
// - separate settings per camera source type
// - control unit holds timing, recognition, status
// - ready to host while able to accept
`timescale 1ns/1ns
`default_nettype none
module vbd_decommutator #(
	parameter int BYTE_PERIOD = vbd_pkg::BYTE_PERIOD_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// host side
	input wire logic [vbd_pkg::BYTE_W-1:0] host_data,
	input wire logic host_stb,
	input wire logic host_start,
	input wire logic host_cam_sel,
	output logic host_ready,
	// operator panel and protection
	input wire logic panel_auto,
	input wire logic panel_start,
	input wire logic panel_cam_sel,
	input wire logic test_en,
	input wire logic [1:0] test_pattern,
	input wire logic power_fail,
	// identification display
	output logic [vbd_pkg::BYTE_W:0] ident_char,
	output logic [vbd_pkg::IDENT_POS_W-1:0] ident_pos,
	output logic ident_stb,
	// video conversion
	output logic [vbd_pkg::BYTE_W-1:0] dac_code,
	output logic dac_convert,
	// scan chain
	output logic vert_gate,
	output logic horiz_gate,
	output logic cathode_bias_en,
	output logic film_advance,
	// status
	output logic display_run,
	output logic auto_mode
);
	import vbd_pkg::*;

	localparam int SYNC_W = BYTE_W + 10;
	localparam int DIV_W = $clog2(BYTE_PERIOD + 1);

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic stb_prev_reg;
	logic [BYTE_W-1:0] s_data;
	logic s_stb, s_start, s_cam, s_auto, s_pstart, s_pcam, s_test, s_pf;
	logic [1:0] s_pat;
	logic [DIV_W-1:0] div_reg;
	logic byte_en;
	logic cam_reg;
	logic [BYTE_W-1:0] pat_data;
	logic pat_valid;
	logic in_valid;
	logic [BYTE_W-1:0] in_data;
	logic [BYTE_W-1:0] dly_reg [DELAY_BYTES];
	logic [DELAY_BYTES-1:0] vld_reg;
	logic [CODE_W-1:0] window;
	logic frame_hit, line_hit, ident_hit, any_hit;
	logic out_valid;
	vbd_route_t route_reg;
	logic [RET_W-1:0] hret_reg;
	logic [RET_W-1:0] vret_reg;
	logic [LINE_W-1:0] line_reg;
	logic [LINE_W-1:0] frame_lines;

	// pin inputs pass two flops; only sync2 is read by logic
	always_ff @(posedge core_clk) begin
		sync1_reg <= {host_data, host_stb, host_start, host_cam_sel, panel_auto,
			panel_start, panel_cam_sel, test_en, test_pattern, power_fail};
		sync2_reg <= sync1_reg;
		stb_prev_reg <= s_stb;
	end
	assign {s_data, s_stb, s_start, s_cam, s_auto, s_pstart, s_pcam, s_test, s_pat, s_pf} =
		sync2_reg;

	// control unit: command source follows the mode switch
	always_ff @(posedge core_clk) begin
		if (srst) begin
			auto_mode <= 1'b0;
			display_run <= 1'b0;
			cam_reg <= 1'b0;
			host_ready <= 1'b0;
		end else begin
			auto_mode <= s_auto;
			display_run <= s_auto ? s_start : s_pstart;
			// camera settings only change between display runs
			if (!display_run) begin
				cam_reg <= s_auto ? s_cam : s_pcam;
			end
			host_ready <= display_run && !s_test && s_auto;
		end
	end

	// byte-rate enable for the test source
	always_ff @(posedge core_clk) begin
		if (srst || div_reg == DIV_W'(BYTE_PERIOD - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + DIV_W'(1);
		end
	end
	assign byte_en = (div_reg == DIV_W'(BYTE_PERIOD - 1));

	vbd_pattern_gen u_pattern (
		.core_clk(core_clk),
		.srst(srst),
		.gen_run(display_run && s_test),
		.byte_en(byte_en),
		.cam_sel(cam_reg),
		.pattern_sel(s_pat),
		.pat_data(pat_data),
		.pat_valid(pat_valid)
	);

	// a host byte is taken on the strobe's rising edge while ready; nothing is taken once
	// the run stops, so a byte in flight cannot command a late conversion
	assign in_valid = display_run &&
		(s_test ? pat_valid : (s_stb && !stb_prev_reg && host_ready));
	assign in_data = s_test ? pat_data : s_data;

	// codes are matched across the incoming byte and three held bytes
	assign window = {dly_reg[2], dly_reg[1], dly_reg[0], in_data};
	assign frame_hit = in_valid && (window == FRAME_CODE) && (&vld_reg[2:0]);
	assign line_hit = in_valid && (window == LINE_CODE) && (&vld_reg[2:0]);
	assign ident_hit = in_valid && (window == IDENT_CODE) && (&vld_reg[2:0]);
	assign any_hit = frame_hit || line_hit || ident_hit;
	assign out_valid = in_valid && vld_reg[DELAY_BYTES-1];

	// the matched code bytes are dropped so they never reach a consumer
	always_ff @(posedge core_clk) begin
		if (srst || !display_run) begin
			vld_reg <= '0;
		end else if (in_valid) begin
			vld_reg <= any_hit ? '0 : {vld_reg[DELAY_BYTES-2:0], 1'b1};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < DELAY_BYTES; gi++) begin : g_dly
			always_ff @(posedge core_clk) begin
				if (srst) begin
					dly_reg[gi] <= '0;
				end else if (in_valid) begin
					dly_reg[gi] <= (gi == 0) ? in_data : dly_reg[(gi == 0) ? 0 : gi - 1];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (srst || !display_run) begin
			route_reg <= VBD_ROUTE_NONE;
		end else if (frame_hit || line_hit) begin
			route_reg <= VBD_ROUTE_VIDEO;
		end else if (ident_hit) begin
			route_reg <= VBD_ROUTE_IDENT;
		end
	end

	// video path: a conversion is commanded only for routed video bytes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dac_code <= '0;
			dac_convert <= 1'b0;
		end else begin
			dac_convert <= out_valid && route_reg == VBD_ROUTE_VIDEO;
			if (out_valid && route_reg == VBD_ROUTE_VIDEO) begin
				dac_code <= dly_reg[DELAY_BYTES-1];
			end
		end
	end

	// identification formatter; characters from position 31 on are dropped
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ident_char <= '0;
			ident_pos <= '0;
			ident_stb <= 1'b0;
		end else begin
			ident_stb <= 1'b0;
			if (ident_hit) begin
				ident_pos <= '0;
			end else if (out_valid && route_reg == VBD_ROUTE_IDENT && !(&ident_pos)) begin
				ident_char <= {1'b0, dly_reg[DELAY_BYTES-1]} + IDENT_CHAR_BASE;
				ident_stb <= 1'b1;
			end
			if (ident_stb) begin
				ident_pos <= ident_pos + IDENT_POS_W'(1);
			end
		end
	end

	// sync driver: retrace gates, line count and film advance
	assign frame_lines = cam_reg ? LINE_W'(LINES_LANDER) : LINE_W'(LINES_PROBE);
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hret_reg <= '0;
			vret_reg <= '0;
			line_reg <= '0;
			film_advance <= 1'b0;
		end else begin
			film_advance <= 1'b0;
			hret_reg <= (hret_reg != '0) ? hret_reg - RET_W'(1) : hret_reg;
			vret_reg <= (vret_reg != '0) ? vret_reg - RET_W'(1) : vret_reg;
			if (frame_hit) begin
				vret_reg <= RET_W'(VRET_CYC);
				line_reg <= '0;
			end else if (line_hit) begin
				hret_reg <= RET_W'(HRET_CYC);
				if (line_reg == frame_lines - LINE_W'(1)) begin
					film_advance <= 1'b1;
					line_reg <= '0;
				end else begin
					line_reg <= line_reg + LINE_W'(1);
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			vert_gate <= 1'b0;
			horiz_gate <= 1'b0;
			cathode_bias_en <= 1'b0;
		end else begin
			vert_gate <= frame_hit || vret_reg > RET_W'(1);
			horiz_gate <= line_hit || hret_reg > RET_W'(1);
			cathode_bias_en <= display_run && !frame_hit && !line_hit &&
				vret_reg <= RET_W'(1) && hret_reg <= RET_W'(1) && !s_pf;
		end
	end

	sequence vret_seq;
		vert_gate[*8] ##0 !cathode_bias_en;
	endsequence

	frame_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		frame_hit |=> vret_seq)
		else $error("vertical gate not held after frame code");
	bias_retrace_a: assert property (@(posedge core_clk) disable iff (srst)
		(horiz_gate || vert_gate) |-> !cathode_bias_en)
		else $error("cathode bias on during retrace");
	bias_power_a: assert property (@(posedge core_clk) disable iff (srst)
		s_pf |=> !cathode_bias_en)
		else $error("cathode bias on during power failure");
	convert_run_a: assert property (@(posedge core_clk) disable iff (srst)
		dac_convert |-> $past(display_run) && $past(route_reg) == VBD_ROUTE_VIDEO)
		else $error("conversion without command");
	delay_out_a: assert property (@(posedge core_clk) disable iff (srst)
		(out_valid && route_reg == VBD_ROUTE_VIDEO) |=> dac_code == $past(dly_reg[3]))
		else $error("video byte not taken from delay tail");
	code_flush_a: assert property (@(posedge core_clk) disable iff (srst)
		(any_hit && display_run) |=> vld_reg == '0 ##1 !out_valid)
		else $error("code bytes not flushed");
	ident_route_a: assert property (@(posedge core_clk) disable iff (srst)
		(ident_hit && display_run) |=> route_reg == VBD_ROUTE_IDENT)
		else $error("identification routing not set");
	advance_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
		film_advance |-> $past(line_hit) && line_reg == '0 ##1 !film_advance)
		else $error("film advance not a single end of frame pulse");
	host_take_a: assert property (@(posedge core_clk) disable iff (srst)
		(in_valid && !s_test) |-> host_ready)
		else $error("host byte taken while not ready");
endmodule
`default_nettype wire

// ---- design/vbd_pattern_gen.sv ----
// test pattern source standing in for the host byte stream
// assumes byte_en is a one-cycle pulse at the byte rate from the same clock
`timescale 1ns/1ns
`default_nettype none
module vbd_pattern_gen #(
	parameter int SAMPLES = vbd_pkg::SAMPLES_PER_LINE
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// control
	input wire logic gen_run,
	input wire logic byte_en,
	input wire logic cam_sel,
	input wire logic [1:0] pattern_sel,
	// generated stream
	output logic [vbd_pkg::BYTE_W-1:0] pat_data,
	output logic pat_valid
);
	import vbd_pkg::*;

	vbd_pg_state_t state_reg;
	logic [1:0] code_idx_reg;
	logic [LINE_W-1:0] line_reg;
	logic [LINE_W-1:0] col_reg;
	logic [LINE_W-1:0] last_line;
	logic [CODE_W-1:0] code_word;
	logic [BYTE_W-1:0] sample;

	assign last_line = cam_sel ? LINE_W'(LINES_LANDER - 1) : LINE_W'(LINES_PROBE - 1);
	assign code_word = (state_reg == VBD_PG_FRAME) ? FRAME_CODE : LINE_CODE;

	always_comb begin
		unique case (pattern_sel)
			PAT_BARS: sample = {col_reg[7:5], 3'h0};
			// never all zeros or all ones, so alternating samples cannot form a sync code
			PAT_RESOLUTION: sample = {1'b0, {(BYTE_W - 2){col_reg[0] ^ line_reg[0]}}, 1'b1};
			PAT_GREY: sample = col_reg[BYTE_W-1:0];
			default: sample = 6'h20;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst || !gen_run) begin
			state_reg <= VBD_PG_FRAME;
			code_idx_reg <= 2'h0;
			line_reg <= '0;
			col_reg <= '0;
		end else if (byte_en) begin
			unique case (state_reg)
				VBD_PG_FRAME, VBD_PG_LINE: begin
					code_idx_reg <= code_idx_reg + 2'h1;
					if (code_idx_reg == 2'h3) begin
						state_reg <= VBD_PG_SAMPLES;
						col_reg <= '0;
					end
				end
				VBD_PG_SAMPLES: begin
					col_reg <= col_reg + LINE_W'(1);
					if (col_reg == LINE_W'(SAMPLES - 1)) begin
						if (line_reg == last_line) begin
							line_reg <= '0;
							state_reg <= VBD_PG_FRAME;
						end else begin
							line_reg <= line_reg + LINE_W'(1);
							state_reg <= VBD_PG_LINE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pat_data <= '0;
			pat_valid <= 1'b0;
		end else begin
			pat_valid <= gen_run && byte_en;
			if (state_reg == VBD_PG_SAMPLES) begin
				pat_data <= sample;
			end else begin
				pat_data <= code_word[(3 - code_idx_reg) * BYTE_W +: BYTE_W];
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/vbd_decommutator_tb.sv ----
// self-checking bench for the video byte decommutator
// assumes the host model drives host_data and host_stb and the bench drives host_start, host_cam_sel and the panel
`timescale 1ns/1ns
`default_nettype none
module vbd_decommutator_tb;
	import vbd_pkg::*;
	typedef struct {logic [BYTE_W-1:0] din; logic [BYTE_W-1:0] dexp;} vbd_row_t;
	logic core_clk, srst, host_start, host_cam_sel, panel_auto, panel_start, panel_cam_sel;
	logic test_en, power_fail, host_stb, host_ready, ident_stb, dac_convert, vert_gate;
	logic horiz_gate, cathode_bias_en, film_advance, display_run, auto_mode;
	logic [1:0] test_pattern;
	logic [BYTE_W-1:0] host_data, dac_code;
	logic [BYTE_W:0] ident_char;
	logic [IDENT_POS_W-1:0] ident_pos;
	logic [BYTE_W-1:0] vid_q[$];
	logic [BYTE_W:0] id_q[$];
	logic [IDENT_POS_W-1:0] pos_q[$];
	int miscompares = 0, check_count = 0, fa_cnt = 0, vrun = 0, hrun = 0, vlen = 0, hlen = 0;
	vbd_row_t rows[6] = '{'{6'h01, 6'h01}, '{6'h3E, 6'h3E}, '{6'h15, 6'h15},
		'{6'h2A, 6'h2A}, '{6'h07, 6'h07}, '{6'h30, 6'h30}};

	vbd_decommutator #(.BYTE_PERIOD(8)) vbd_decommutator_i (.core_clk(core_clk), .srst(srst),
		.host_data(host_data), .host_stb(host_stb), .host_start(host_start),
		.host_cam_sel(host_cam_sel), .host_ready(host_ready), .panel_auto(panel_auto),
		.panel_start(panel_start), .panel_cam_sel(panel_cam_sel), .test_en(test_en),
		.test_pattern(test_pattern), .power_fail(power_fail), .ident_char(ident_char),
		.ident_pos(ident_pos), .ident_stb(ident_stb), .dac_code(dac_code),
		.dac_convert(dac_convert), .vert_gate(vert_gate), .horiz_gate(horiz_gate),
		.cathode_bias_en(cathode_bias_en), .film_advance(film_advance),
		.display_run(display_run), .auto_mode(auto_mode));
	vbd_host_model vbd_host_model_i (.core_clk(core_clk), .host_ready(host_ready),
		.host_data(host_data), .host_stb(host_stb));

	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	// collect strobed outputs and measure gate lengths
	always @(posedge core_clk) begin
		if (dac_convert === 1'b1) vid_q.push_back(dac_code);
		if (ident_stb === 1'b1) begin
			id_q.push_back(ident_char);
			pos_q.push_back(ident_pos);
		end
		if (film_advance === 1'b1) fa_cnt++;
		vrun = (vert_gate === 1'b1) ? vrun + 1 : 0;
		hrun = (horiz_gate === 1'b1) ? hrun + 1 : 0;
		if (vrun != 0) vlen = vrun;
		if (hrun != 0) hlen = hrun;
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t value %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// film advance must wait for exactly the line count of the chosen camera
	task automatic film_run(input logic cam, input int lines);
		int f0;
		srst <= 1'b1;
		host_cam_sel <= cam;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		repeat (6) @(posedge core_clk);
		f0 = fa_cnt;
		host_i_frame();
		for (int i = 1; i < lines; i++) vbd_host_model_i.send_code(LINE_CODE, 1);
		chk_val(fa_cnt, f0);
		vbd_host_model_i.send_code(LINE_CODE, 1);
		repeat (4) @(posedge core_clk);
		chk_val(fa_cnt, f0 + 1);
	endtask
	task automatic host_i_frame();
		vbd_host_model_i.send_code(FRAME_CODE, 1);
	endtask

	initial begin
		#1_000_000;
		miscompares++;
		$display("BAD %0t watchdog expired", $time);
		give_verdict();
	end

	initial begin
		srst = 1'b1;
		{host_start, host_cam_sel, panel_auto, panel_start, panel_cam_sel} = '0;
		{test_en, power_fail} = '0;
		test_pattern = 2'h0;
		repeat (8) @(posedge core_clk);
		chk_val({host_ready, dac_convert, vert_gate, cathode_bias_en, display_run}, 0);
		srst <= 1'b0;
		panel_auto <= 1'b1;
		host_start <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk_bit(auto_mode, 1'b1);
		chk_bit(host_ready, 1'b1);
		chk_bit(cathode_bias_en, 1'b1);
		host_i_frame();
		chk_bit(vert_gate, 1'b1);
		chk_bit(cathode_bias_en, 1'b0);
		foreach (rows[i]) vbd_host_model_i.send(rows[i].din, 1);
		vbd_host_model_i.send_code(LINE_CODE, 1);
		repeat (20) @(posedge core_clk);
		chk_val(vid_q.size(), 6);
		foreach (rows[i]) chk_val(vid_q[i], rows[i].dexp);
		chk_val(vlen, VRET_CYC);
		chk_val(hlen, HRET_CYC);
		vbd_host_model_i.send_code(IDENT_CODE, 1);
		for (int i = 1; i <= 3; i++) vbd_host_model_i.send(i[BYTE_W-1:0], 1);
		vbd_host_model_i.send_code(LINE_CODE, 1);
		repeat (20) @(posedge core_clk);
		for (int i = 0; i < 3; i++) begin
			chk_val(id_q[i], IDENT_CHAR_BASE + i + 1);
			chk_val(pos_q[i], i);
		end
		chk_val(vid_q.size(), 6);
		power_fail <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk_bit(cathode_bias_en, 1'b0);
		power_fail <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk_bit(cathode_bias_en, 1'b1);
		film_run(1'b0, LINES_PROBE);
		film_run(1'b1, LINES_LANDER);
		panel_auto <= 1'b0;
		panel_start <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk_val({display_run, auto_mode, host_ready}, 3'b100);
		vbd_host_model_i.send_code(FRAME_CODE, 0);
		chk_bit(vert_gate, 1'b0);
		test_en <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			test_pattern <= p[1:0];
			vid_q.delete();
			repeat (200) @(posedge core_clk);
			chk_bit(vid_q.size() > 0, 1'b1);
			chk_bit(host_ready, 1'b0);
		end
		panel_start <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk_bit(display_run, 1'b0);
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- tb/vbd_host_model.sv ----
// host computer model: sends six-bit bytes with a strobe handshake
// assumes the design samples host pins through two flops on core_clk
`timescale 1ns/1ns
`default_nettype none
module vbd_host_model (
	// clock
	input wire logic core_clk,
	// host pins
	input wire logic host_ready,
	output logic [vbd_pkg::BYTE_W-1:0] host_data,
	output logic host_stb
);
	import vbd_pkg::*;
	initial begin
		host_data = '0;
		host_stb = 1'b0;
	end
	// whole byte per strobe, sent once ready or after 1000 cycles unless told not to wait
	task automatic send(input logic [BYTE_W-1:0] b, input bit wait_rdy);
		int n;
		n = 0;
		while (wait_rdy && host_ready !== 1'b1 && n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		host_data <= b;
		host_stb <= 1'b1;
		repeat (3) @(posedge core_clk);
		host_stb <= 1'b0;
		// hold time is over, so a stale byte must not linger on the lines
		host_data <= ~b;
		repeat (3) @(posedge core_clk);
	endtask
	// first byte of a code goes out first
	task automatic send_code(input logic [CODE_W-1:0] c, input bit wait_rdy);
		for (int i = 3; i >= 0; i--) send(c[i*BYTE_W +: BYTE_W], wait_rdy);
	endtask
endmodule
`default_nettype wire
